// file: hw/monitor_id_and_alert_setup.sv
`timescale 1ns/1ps
`default_nettype none

module monitor_id_and_alert_setup
	import monitor_id_pkg::*;
#(
	parameter logic [11:0] PART_CODE = 12'h5a5, // Arbitrary value
	parameter logic [3:0]  REV_CODE  = 4'h1     // Arbitrary value
) (
	input  wire logic      i_clock,
	input  wire logic      i_sys_rst,
	input  wire reg_req_t  i_req,
	input  wire meas_t     i_meas,
	output logic [15:0]    o_rdata,
	output logic           o_rvalid,
	output logic [15:0]    o_config,
	output logic           o_alert_out,
	output logic           o_alert_oe
);

	localparam logic [15:0] DIE_WORD = {PART_CODE, REV_CODE}; // Part code on top, revision below

	logic [15:0] cfg_ff;
	logic [15:0] alsel_ff;
	logic [15:0] limit_ff;
	logic        aff_ff;
	logic        conversion_done_flag_ff;
	logic        ovf_ff;
	logic [15:0] rdata_ff;
	logic        rvalid_ff;
	logic        alert_oe_ff;
	logic        alert_out_ff;

	// Access decode
	wire wr_cfg      = i_req.wr && (i_req.ptr == PTR_CONFIG);
	wire wr_alert    = i_req.wr && (i_req.ptr == PTR_ALERT);
	wire wr_limit    = i_req.wr && (i_req.ptr == PTR_LIMIT);
	wire rd_alert    = i_req.rd && (i_req.ptr == PTR_ALERT);
	wire soft_rst    = wr_cfg && i_req.wdata[CFG_SOFT_RST];
	wire [2:0] wmode = i_req.wdata[2:0];
	// Selecting power-down does not disturb the ready flag
	wire cfg_clr     = wr_cfg && !soft_rst && (wmode != MODE_PWR_DOWN) && (wmode != MODE_PWR_DOWN2);

	// Only the highest enabled limit function is compared
	wire en_so = alsel_ff[AL_SHUNT_OVER];
	wire en_su = alsel_ff[AL_SHUNT_UNDER];
	wire en_bo = alsel_ff[AL_BUS_OVER];
	wire en_bu = alsel_ff[AL_BUS_UNDER];
	wire en_po = alsel_ff[AL_POWER_OVER];
	wire sel_so = en_so;
	wire sel_su = en_su && !en_so;
	wire sel_bo = en_bo && !en_so && !en_su;
	wire sel_bu = en_bu && !en_so && !en_su && !en_bo;
	wire sel_po = en_po && !en_so && !en_su && !en_bo && !en_bu;

	// Shunt readings are signed; bus and power are unsigned magnitudes
	wire fault = (sel_so && ($signed(i_meas.shunt) > $signed(limit_ff)))
		|| (sel_su && ($signed(i_meas.shunt) < $signed(limit_ff)))
		|| (sel_bo && (i_meas.bus > limit_ff))
		|| (sel_bu && (i_meas.bus < limit_ff))
		|| (sel_po && (i_meas.power > limit_ff));

	// Source flag: a new fault wins over a clearing read in the same cycle
	wire aff_set   = i_meas.done && fault;
	wire aff_clr   = alsel_ff[AL_LATCH] ? rd_alert : (i_meas.done && !fault);
	wire nxt_aff   = aff_set || (aff_ff && !aff_clr);
	// Ready flag: set wins over a read or a configuration write, but a soft reset write clears it
	wire nxt_conversion_done_flag  = i_meas.done || (conversion_done_flag_ff && !rd_alert && !cfg_clr);
	wire nxt_ovf   = i_meas.done ? i_meas.ovf : ovf_ff;

	// Pin asserts for the limit flag or, when enabled, conversion ready
	wire alert_act = aff_ff || (alsel_ff[AL_READY_EN] && conversion_done_flag_ff);
	// Open-drain pin pulls low when the active level is low
	wire nxt_alert_oe = alert_act ^ alsel_ff[AL_POLARITY];

	// Read image of the alert word: flags sit in their fixed slots
	wire [15:0] alert_img = {alsel_ff[15:10], 5'h00, aff_ff, conversion_done_flag_ff, ovf_ff, alsel_ff[1:0]};

	// Read mux; unmapped pointers return zero and die word is a constant
	wire [15:0] nxt_rdata = (i_req.ptr == PTR_CONFIG) ? cfg_ff :
		(i_req.ptr == PTR_ALERT) ? alert_img :
		(i_req.ptr == PTR_LIMIT) ? limit_ff :
		(i_req.ptr == PTR_DIE)   ? DIE_WORD : 16'h0000;

	// Configuration word; soft reset self-clears and restores every register
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cfg_ff <= CFG_RESET;
		end else if (soft_rst) begin
			cfg_ff <= CFG_RESET;
		end else if (wr_cfg) begin
			cfg_ff <= i_req.wdata & CFG_WR_MASK;
		end
	end

	// Alert select and threshold; writes to the die pointer fall through untouched
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			alsel_ff <= AL_RESET;
			limit_ff <= LIMIT_RESET;
		end else if (soft_rst) begin
			alsel_ff <= AL_RESET;
			limit_ff <= LIMIT_RESET;
		end else begin
			if (wr_alert) begin
				alsel_ff <= i_req.wdata & AL_WR_MASK;
			end
			if (wr_limit) begin
				limit_ff <= i_req.wdata;
			end
		end
	end

	// Status flags
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			aff_ff  <= 1'b0;
			conversion_done_flag_ff <= 1'b0;
			ovf_ff  <= 1'b0;
		end else if (soft_rst) begin
			aff_ff  <= 1'b0;
			conversion_done_flag_ff <= 1'b0;
			ovf_ff  <= 1'b0;
		end else begin
			aff_ff  <= nxt_aff;
			conversion_done_flag_ff <= nxt_conversion_done_flag;
			ovf_ff  <= nxt_ovf;
		end
	end

	// Read data and pin, both registered so outputs never glitch
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_ff     <= 16'h0000;
			rvalid_ff    <= 1'b0;
			alert_oe_ff  <= 1'b0;
			alert_out_ff <= 1'b0;
		end else begin
			rdata_ff     <= i_req.rd ? nxt_rdata : rdata_ff;
			rvalid_ff    <= i_req.rd;
			alert_oe_ff  <= nxt_alert_oe;
			alert_out_ff <= 1'b0;
		end
	end

	assign o_rdata     = rdata_ff;
	assign o_rvalid    = rvalid_ff;
	assign o_config    = cfg_ff;
	assign o_alert_oe  = alert_oe_ff;
	assign o_alert_out = alert_out_ff;

	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	// Register, identity, limit selection, latch and pin checks
	a_die_read_const: assert property (i_req.rd && i_req.ptr == PTR_DIE |=> o_rdata == DIE_WORD)
		else $error("die identity read returned wrong word");
	a_die_part_code: assert property (i_req.rd && i_req.ptr == PTR_DIE |=> o_rdata[15:4] == PART_CODE)
		else $error("part code field wrong");
	a_die_rev_code: assert property (i_req.rd && i_req.ptr == PTR_DIE |=> o_rdata[3:0] == REV_CODE)
		else $error("revision field wrong");
	a_one_source: assert property (en_so && i_meas.done && !aff_ff && !soft_rst
		&& !($signed(i_meas.shunt) > $signed(limit_ff)) |=> !aff_ff)
		else $error("lower limit function leaked into the flag");
	a_ready_alert: assert property (alsel_ff[AL_READY_EN] && conversion_done_flag_ff && !alsel_ff[AL_POLARITY] |=> o_alert_oe)
		else $error("ready alert not driven");
	a_config_store: assert property (wr_cfg && !soft_rst |=> cfg_ff == ($past(i_req.wdata) & CFG_WR_MASK))
		else $error("configuration write lost");
	a_alert_layout: assert property (rd_alert |=> o_rdata[9:5] == 5'h00 && o_rdata[4] == $past(aff_ff))
		else $error("alert word layout wrong");
	a_limit_store: assert property (wr_limit && !soft_rst |=> limit_ff == $past(i_req.wdata))
		else $error("threshold write lost");
	a_priority_top: assert property (en_so && en_bu && i_meas.done && !soft_rst
		&& ($signed(i_meas.shunt) > $signed(limit_ff)) |=> aff_ff)
		else $error("top priority fault missed");
	a_latch_hold: assert property (aff_ff && alsel_ff[AL_LATCH] && !rd_alert && !soft_rst |=> aff_ff)
		else $error("latched flag dropped early");
	a_polarity_pin: assert property (##1 o_alert_oe == ($past(alert_act) ^ $past(alsel_ff[AL_POLARITY])))
		else $error("alert pin level wrong");
	a_die_write_ign: assert property (i_req.wr && i_req.ptr == PTR_DIE
		|=> $stable(cfg_ff) && $stable(limit_ff) && $stable(alsel_ff))
		else $error("die write disturbed registers");

	// Flag priority, reset and pin level checks
	a_flag_set_wins: assert property (aff_set && !soft_rst |=> aff_ff)
		else $error("clearing read beat a new fault");
	a_transp_clear: assert property (!alsel_ff[AL_LATCH] && i_meas.done && !fault && !soft_rst |=> !aff_ff)
		else $error("transparent flag did not follow the fault");
	a_ready_set_wins: assert property (i_meas.done && !soft_rst |=> conversion_done_flag_ff)
		else $error("ready flag not set by a conversion");
	a_soft_reset_all: assert property (soft_rst |=> cfg_ff == CFG_RESET && alsel_ff == AL_RESET
		&& limit_ff == LIMIT_RESET && !aff_ff && !conversion_done_flag_ff)
		else $error("soft reset left state behind");
	a_active_high: assert property (alsel_ff[AL_POLARITY] && alert_act |=> !o_alert_oe)
		else $error("inverted alert still pulled low");

	// Main scenarios
	c_die_read: cover property (i_req.rd && i_req.ptr == PTR_DIE ##1 o_rvalid);
	c_soft_reset: cover property (soft_rst ##1 cfg_ff == CFG_RESET);
	c_active_high: cover property (alsel_ff[AL_POLARITY] && aff_ff ##1 !o_alert_oe);
	c_latched_alert: cover property (aff_ff && alsel_ff[AL_LATCH] ##1 rd_alert ##1 !aff_ff);
	c_ready_alert: cover property (i_meas.done && alsel_ff[AL_READY_EN] ##2 o_alert_oe);

endmodule : monitor_id_and_alert_setup

`default_nettype wire

// file: hw/monitor_id_pkg.sv
package monitor_id_pkg;

	// Register pointers
	localparam logic [7:0]  PTR_CONFIG      = 8'h00;
	localparam logic [7:0]  PTR_ALERT       = 8'h06;
	localparam logic [7:0]  PTR_LIMIT       = 8'h07;
	localparam logic [7:0]  PTR_DIE         = 8'hff;

	// Configuration word fields
	localparam int          CFG_SOFT_RST    = 15;
	localparam logic [15:0] CFG_WR_MASK     = 16'h0fff;
	localparam logic [15:0] CFG_RESET       = 16'h0000;
	localparam logic [2:0]  MODE_PWR_DOWN   = 3'h0;
	localparam logic [2:0]  MODE_PWR_DOWN2  = 3'h4;

	// Alert select word fields
	localparam int          AL_SHUNT_OVER   = 15;
	localparam int          AL_SHUNT_UNDER  = 14;
	localparam int          AL_BUS_OVER     = 13;
	localparam int          AL_BUS_UNDER    = 12;
	localparam int          AL_POWER_OVER   = 11;
	localparam int          AL_READY_EN     = 10;
	localparam int          AL_SRC_FLAG     = 4;
	localparam int          AL_DONE_FLAG    = 3;
	localparam int          AL_OVF_FLAG     = 2;
	localparam int          AL_POLARITY     = 1;
	localparam int          AL_LATCH        = 0;
	localparam logic [15:0] AL_WR_MASK      = 16'hfc03;
	localparam logic [15:0] AL_RESET        = 16'h0000;
	localparam logic [15:0] LIMIT_RESET     = 16'h0000;

	// Die identity layout
	localparam int          DIE_PART_LSB    = 4;
	localparam int          DIE_PART_W      = 12;
	localparam int          DIE_REV_W       = 4;

	// Register access request from the serial front end
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  ptr;
		logic [15:0] wdata;
	} reg_req_t;

	// Results of one finished conversion
	typedef struct packed {
		logic        done;
		logic        ovf;
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] power;
	} meas_t;

endpackage : monitor_id_pkg

// file: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Serial host stand-in: one request becomes a one-cycle register strobe
module host_model
	import monitor_id_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_go,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_ptr,
	input  wire logic [15:0] i_wdata,
	output var  reg_req_t    o_req
);
	// Strobe is rebuilt every edge so a request is never taken twice
	always_ff @(posedge i_clock) begin
		o_req <= '{wr: i_go & i_wr, rd: i_go & ~i_wr, ptr: i_ptr, wdata: i_wdata};
	end
endmodule : host_model

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import monitor_id_pkg::*;
	localparam logic [11:0] PART = 12'h3c7; // Arbitrary value
	localparam logic [3:0]  REV  = 4'h9;    // Arbitrary value
	logic        i_clock, i_sys_rst, go, wr, o_rvalid, o_alert_out, o_alert_oe, f;
	logic [7:0]  ptr;
	logic [15:0] wd, rd_word, o_rdata, o_config, v, lim, sel;
	logic [31:0] seed = 32'd40;
	reg_req_t    req;
	meas_t       meas, m;
	int          errors = 0, checked = 0, cycles = 0;

	host_model host (.i_clock(i_clock), .i_go(go), .i_wr(wr), .i_ptr(ptr), .i_wdata(wd), .o_req(req));
	monitor_id_and_alert_setup #(.PART_CODE(PART), .REV_CODE(REV)) dut (.i_clock(i_clock),
		.i_sys_rst(i_sys_rst), .i_req(req), .i_meas(meas), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.o_config(o_config), .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe));

	// 40 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd

	// Highest enable wins; strict compares, operands kept positive so signedness cannot matter
	function automatic logic fault(input logic [15:0] s, input meas_t x, input logic [15:0] l);
		if (s[15]) return x.shunt > l;
		if (s[14]) return x.shunt < l;
		if (s[13]) return x.bus > l;
		if (s[12]) return x.bus < l;
		if (s[11]) return x.power > l;
		return 1'b0;
	endfunction : fault

	task automatic report_and_stop();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One register access; read data lands one edge after the host strobe is built
	task automatic acc(input logic w, input logic [7:0] p, input logic [15:0] d);
		@(posedge i_clock);
		go <= 1'b1;
		wr <= w;
		ptr <= p;
		wd <= d;
		@(posedge i_clock);
		go <= 1'b0;
		@(posedge i_clock);
		#1;
		rd_word = o_rdata;
		chk({15'h0, o_rvalid}, {15'h0, ~w});
	endtask : acc

	// Conversion result: flags at the taking edge, pin one edge later
	task automatic conv(input meas_t x);
		@(posedge i_clock);
		meas <= x;
		@(posedge i_clock);
		meas.done <= 1'b0;
		@(posedge i_clock);
		#1;
	endtask : conv

	// Hang guard
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		{go, wr, ptr, wd} = '0;
		meas = '0;
		i_sys_rst = 1'b1;
		repeat (8) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		#1;
		chk({15'h0, o_alert_oe}, 16'h0);
		acc(1'b0, PTR_DIE, 16'h0);
		chk(rd_word, {PART, REV});
		acc(1'b1, PTR_DIE, rnd());
		acc(1'b0, PTR_DIE, 16'h0);
		chk(rd_word, {PART, REV});
		acc(1'b0, 8'h05, 16'h0);
		chk(rd_word, 16'h0);
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			acc(1'b1, PTR_CONFIG, v);
			chk(o_config, v[CFG_SOFT_RST] ? CFG_RESET : (v & CFG_WR_MASK));
			acc(1'b1, PTR_LIMIT, ~v);
			acc(1'b0, PTR_LIMIT, 16'h0);
			chk(rd_word, ~v);
		end
		// Configuration, then alert select, then threshold, before each conversion
		for (int i = 0; i < 30; i++) begin
			lim = rnd() & 16'h7fff;
			sel = rnd() & 16'hfc02;
			m = '{done: 1'b1, ovf: 1'(rnd() >> 15), shunt: rnd() & 16'h7fff, bus: rnd() & 16'h7fff,
				power: rnd() & 16'h7fff};
			if (i < 2) m.shunt = lim; // Equality must not trip
			acc(1'b1, PTR_CONFIG, 16'h0007);
			acc(1'b1, PTR_ALERT, sel);
			acc(1'b1, PTR_LIMIT, lim);
			conv(m);
			f = fault(sel, m, lim);
			chk({15'h0, o_alert_oe}, {15'h0, (f | sel[10]) ^ sel[1]});
			chk({15'h0, o_alert_out}, 16'h0);
			acc(1'b0, PTR_ALERT, 16'h0);
			chk(rd_word, sel | {11'h0, f, 1'b1, m.ovf, 2'h0});
		end
		// Latched alert survives a clean conversion until the alert word is read
		acc(1'b1, PTR_ALERT, 16'h8001);
		acc(1'b0, PTR_ALERT, 16'h0); // Clears a flag left over from the loop
		acc(1'b1, PTR_LIMIT, 16'h0010);
		conv('{done: 1'b1, ovf: 1'b0, shunt: 16'h0020, bus: 16'h0, power: 16'h0});
		conv('{done: 1'b1, ovf: 1'b0, shunt: 16'h0000, bus: 16'h0, power: 16'h0});
		chk({15'h0, o_alert_oe}, 16'h1);
		acc(1'b0, PTR_ALERT, 16'h0);
		chk(rd_word, 16'h8019);
		@(posedge i_clock);
		#1;
		chk({15'h0, o_alert_oe}, 16'h0);
		// Power-down selection leaves the ready flag standing
		conv('{done: 1'b1, ovf: 1'b0, shunt: 16'h0000, bus: 16'h0, power: 16'h0});
		acc(1'b1, PTR_CONFIG, 16'h0004);
		acc(1'b0, PTR_ALERT, 16'h0);
		chk(rd_word, 16'h8009);
		// Soft reset clears the whole bank
		acc(1'b1, PTR_CONFIG, 16'h8000);
		chk(o_config, CFG_RESET);
		acc(1'b0, PTR_ALERT, 16'h0);
		chk(rd_word, 16'h0);
		acc(1'b0, PTR_LIMIT, 16'h0);
		chk(rd_word, 16'h0);
		// Mid-run hard reset wipes a freshly written threshold
		acc(1'b1, PTR_LIMIT, 16'h0abc);
		@(posedge i_clock);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		acc(1'b0, PTR_LIMIT, 16'h0);
		chk(rd_word, LIMIT_RESET);
		chk({15'h0, o_alert_oe}, 16'h0);
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
